// >>> rtl/xss_pkg.sv
// Shared constants, types and helpers of the extended state save block
package xss_pkg;
  // Register byte offsets on the APB window
  localparam logic [11:0] CTRL4_OFF = 12'h000;
  localparam logic [11:0] MODE_OFF  = 12'h004;
  localparam logic [11:0] OPLO_OFF  = 12'h008;
  localparam logic [11:0] OPHI_OFF  = 12'h00c;
  localparam logic [11:0] CMD_OFF   = 12'h010;
  localparam logic [11:0] STAT_OFF  = 12'h014;
  localparam logic [11:0] RESLO_OFF = 12'h018;
  localparam logic [11:0] RESHI_OFF = 12'h01c;
  localparam logic [11:0] BASE_OFF  = 12'h020;
  localparam logic [11:0] ENFN_OFF  = 12'h024;
  localparam logic [11:0] ENSUB_OFF = 12'h028;
  localparam logic [11:0] ENA_OFF   = 12'h02c;
  localparam logic [11:0] ENB_OFF   = 12'h030;
  localparam logic [11:0] SIDX_OFF  = 12'h034;
  localparam logic [11:0] SDATA_OFF = 12'h038;

  localparam int          OS_EN_BIT       = 18;
  localparam logic [63:0] RESET_MASK      = 64'h0000_0000_0000_0001;
  localparam logic [2:0]  FEAT_SUPPORTED  = 3'h7;
  localparam logic [31:0] ENUM_FN_XST     = 32'h0000_000d;
  localparam logic [31:0] HDR_OFF         = 32'h0000_0200;
  localparam logic [31:0] HDR_HI_OFF      = 32'h0000_0204;
  localparam logic [31:0] EXT_AREA_OFF    = 32'h0000_0240;
  localparam logic [31:0] AREA_SIZE_BASE  = 32'h0000_0240;
  localparam logic [31:0] UPPER_AREA_SIZE = 32'h0000_0100;

  // State store word indices and initial values
  localparam logic [7:0]  FCTL_IDX   = 8'h00;
  localparam logic [7:0]  FSTAT_IDX  = 8'h01;
  localparam logic [7:0]  FTAG_IDX   = 8'h02;
  localparam logic [7:0]  VCS_IDX    = 8'h20;
  localparam logic [7:0]  EXT_IDX    = 8'h80;
  localparam logic [31:0] FCTL_INIT  = 32'h0000_037f;
  localparam logic [31:0] FSTAT_INIT = 32'h0000_0000;
  localparam logic [31:0] FTAG_INIT  = 32'h0000_ffff;
  localparam logic [6:0]  HALF_CNT  = 7'h20;

  // Components: mask bit, first store word, word count; entry 7 is a pad
  localparam int NCOMP = 7;
  localparam int COMP_BIT  [8] = '{0, 1, 2, 9, 11, 12, 62, 63};
  localparam int COMP_BASE [8] = '{0, 64, 128, 192, 193, 195, 198, 199};
  localparam int COMP_CNT  [8] = '{31, 64, 64, 1, 2, 3, 1, 1};

  typedef enum logic [1:0] {MODE_REAL, MODE_V86, MODE_PROT, MODE_LONG}
    xss_opmode_t;
  typedef enum logic [2:0] {CMD_NONE, CMD_VEC, CMD_SAVE, CMD_SAVEOPT,
                            CMD_RESTORE, CMD_GETBV, CMD_SETBV} xss_cmd_t;
  typedef enum logic [1:0] {FLT_NONE, FLT_UD, FLT_GP} xss_fault_t;

  typedef struct packed {
    logic [1:0]  cpl;
    logic        is64;
    logic        sysMgmt;
    xss_opmode_t opMode;
  } xss_cpu_mode_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } xss_mreq_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } xss_mrsp_t;

  function automatic logic maskLegal(input logic [63:0] m);
    return m[0] && (m[63:3] == 61'h0) && (m[2:1] != 2'h2);
  endfunction

  function automatic logic [31:0] initWord(input logic [7:0] idx);
    case (idx)
      FCTL_IDX:  return FCTL_INIT;
      FSTAT_IDX: return FSTAT_INIT;
      FTAG_IDX:  return FTAG_INIT;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Legacy region maps word for word; upper components follow the header
  function automatic logic [31:0] areaOff(input logic [7:0] idx);
    logic [7:0] rel;
    rel = idx - EXT_IDX;
    if (idx < EXT_IDX)
      return {22'h0, idx, 2'h0};
    return EXT_AREA_OFF + {22'h0, rel, 2'h0};
  endfunction
endpackage

// >>> rtl/xss_state_store.sv
// Word store for the processor state components
`timescale 1ns/1ps
module xss_state_store
#(
  parameter int DEPTH = 256,
  parameter int W     = 32,
  parameter int IW    = $clog2(DEPTH)
)
(
  input  wire logic          core_clk,
  input  wire logic          wrEn,
  input  wire logic [IW-1:0] wrIdx,
  input  wire logic [W-1:0]  wrData,
  input  wire logic [IW-1:0] rdIdxA,
  output logic      [W-1:0]  rdDataA,
  input  wire logic [IW-1:0] rdIdxB,
  output logic      [W-1:0]  rdDataB
);
  logic [W-1:0] mem [DEPTH];

  // Architectural state has no reset; only restores change it
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
      mem[wrIdx] <= wrData;
  end

  assign rdDataA = mem[rdIdxA];
  assign rdDataB = mem[rdIdxB];
endmodule // xss_state_store

// >>> rtl/xss_excp_check.sv
// Legality checks for issued instructions
`timescale 1ns/1ps
module xss_excp_check
  import xss_pkg::*;
(
  input  wire xss_cmd_t      cmd,
  input  wire xss_cpu_mode_t mode,
  input  wire logic          osEnable,
  input  wire logic [63:0]   featMask,
  input  wire logic [63:0]   newMask,
  output xss_fault_t         fault
);
  logic vecMode;

  always_comb
  begin
    vecMode = (mode.opMode inside {MODE_PROT, MODE_LONG}) && !mode.sysMgmt;
    fault = FLT_NONE;
    unique case (cmd)
      CMD_VEC:
        if (!vecMode || !osEnable || featMask[2:1] != 2'h3)
          fault = FLT_UD;
      CMD_GETBV:
        if (!osEnable)
          fault = FLT_UD;
      CMD_SETBV:
        if (!osEnable)
          fault = FLT_UD;
        else if (mode.cpl != 2'h0)
          fault = FLT_GP;
        else if (!maskLegal(newMask))
          fault = FLT_GP;
      CMD_NONE, CMD_SAVE, CMD_SAVEOPT, CMD_RESTORE:
        fault = FLT_NONE;
      default:
        fault = FLT_NONE;
    endcase
  end
endmodule // xss_excp_check

// >>> rtl/xss_engine.sv
// Extended state save and restore engine with APB control window
//
// Functional notes
// - Prefix vector ops run in protected/long mode, not system management
// - Upper halves of wide vectors survive every mode change untouched
// - Save and restore run in every mode and may rewrite wide vectors
// - Vector instruction without enabled state management raises invalid op
// - Support enumeration reports 111b in its low three bits
// - Extended vector support implies legacy float and legacy vector
// - Control register read and write need os save enable, bit 18
// - Control register write permitted at ring zero only
// - Enumeration 0000000Dh sub 0 returns area size for enabled features
// - Header at byte 512 starts with 64-bit present bitvector
// - Present bits line up with enabled mask bits
// - Save writes selected components, sets only their present bits
// - Restore touches only components set in operand and mask
// - Present bit set loads from memory, clear loads initial values
// - Float init: control 037Fh, status 0, tags FFFFh, rest zero
// - Narrow vector init clears 16 registers in 64-bit mode, else 8
// - Upper half init clears 16 halves in 64-bit mode, else 8
// - Init disables profiling, clears key rights and shadow stack state; mask bits 9, 11, 12, 62 are never legal, so no restore reaches them
// - Vector control word reloads whenever narrow or upper updated
// - Mask write faults on bits above 2, bit 0 clear, or 10b
// - Mask resets to legacy float component only
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module xss_engine
  import xss_pkg::*;
#(
  parameter int AW = 12
)
(
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output xss_mreq_t          memReq,
  input  wire xss_mrsp_t     memRsp
);
  typedef enum {ST_IDLE, ST_HDR_RD, ST_COMP, ST_XFER, ST_MX, ST_HDR_WR}
    xss_state_t;

  logic [63:0]   featMask_r;
  logic [63:0]   operand_r;
  logic [63:0]   result_r;
  logic [63:0]   present_r;
  logic [63:0]   selMask_r;
  logic [63:0]   hdrNew;
  logic          osEnable_r;
  xss_cpu_mode_t mode_r;
  logic [31:0]   areaBase_r;
  logic [31:0]   enumFn_r;
  logic [31:0]   enumSub_r;
  logic [31:0]   enumA;
  logic [31:0]   enumB;
  logic [31:0]   prdata_r;
  logic [31:0]   rdVal;
  logic [7:0]    stateIdx_r;
  logic          done_r;
  xss_fault_t    fault_r;
  xss_state_t    state_r;
  logic          isSave_r;
  logic          is64_r;
  logic          xfMem_r;
  logic [2:0]    ci_r;
  logic [6:0]    wi_r;
  logic [6:0]    xfCnt_r;
  xss_mreq_t     memReq_r;
  logic          busy;
  logic          wrAcc;
  logic          cmdWr;
  xss_cmd_t      cmd;
  xss_fault_t    chkFault;
  logic          engStart;
  logic          engEnd;
  logic          memAck;
  logic          sel12;
  logic [7:0]    curIdx;
  logic [7:0]    stIdx;
  logic          stWe;
  logic [31:0]   stWd;
  logic [31:0]   stRdA;
  logic [31:0]   stRdB;

  function automatic logic regKnown(input logic [AW-1:0] a);
    return a inside {CTRL4_OFF, MODE_OFF, OPLO_OFF, OPHI_OFF, CMD_OFF,
                     STAT_OFF, RESLO_OFF, RESHI_OFF, BASE_OFF, ENFN_OFF,
                     ENSUB_OFF, ENA_OFF, ENB_OFF, SIDX_OFF, SDATA_OFF};
  endfunction

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !regKnown(paddr);
  assign prdata  = prdata_r;
  assign memReq  = memReq_r;

  assign wrAcc  = psel && penable && pwrite;
  assign busy   = state_r != ST_IDLE;
  assign cmd    = xss_cmd_t'(pwdata[2:0]);
  // New commands are ignored while the engine walks the save area
  assign cmdWr  = wrAcc && paddr == CMD_OFF && !busy;
  // optimized save runs as full save
  assign engStart = cmdWr && chkFault == FLT_NONE &&
                    cmd inside {CMD_SAVE, CMD_SAVEOPT, CMD_RESTORE};

  xss_excp_check xss_excp_check_inst
  (
    .cmd      (cmd),
    .mode     (mode_r),
    .osEnable (osEnable_r),
    .featMask (featMask_r),
    .newMask  (operand_r),
    .fault    (chkFault)
  );

  assign memAck = memReq_r.req && memRsp.ack;
  assign sel12  = selMask_r[1] || selMask_r[2];
  assign curIdx = 8'(COMP_BASE[ci_r]) + {1'b0, wi_r};
  assign stIdx  = (state_r == ST_MX) ? VCS_IDX : curIdx;
  assign hdrNew = present_r | selMask_r;

  assign stWe = !isSave_r &&
                ((state_r == ST_XFER && (!xfMem_r || memAck)) ||
                 (state_r == ST_MX && memAck));
  assign stWd = (state_r == ST_XFER && !xfMem_r) ? initWord(curIdx)
                                                 : memRsp.rdata;

  assign engEnd = (state_r == ST_HDR_WR && memAck && wi_r[0]) ||
                  (state_r == ST_MX && memAck && !isSave_r) ||
                  (state_r == ST_COMP && ci_r == 3'(NCOMP) &&
                   !isSave_r && !sel12);

  xss_state_store #(
    .DEPTH (256),
    .W     (32)
  ) xss_state_store_inst
  (
    .core_clk (core_clk),
    .wrEn     (stWe),
    .wrIdx    (stIdx),
    .wrData   (stWd),
    .rdIdxA   (stIdx),
    .rdDataA  (stRdA),
    .rdIdxB   (stateIdx_r),
    .rdDataB  (stRdB)
  );

  assign enumA = (enumFn_r == ENUM_FN_XST && enumSub_r == 32'h0) ?
                 AREA_SIZE_BASE + (featMask_r[2] ? UPPER_AREA_SIZE
                                                 : 32'h0) : 32'h0;
  assign enumB = (enumFn_r == ENUM_FN_XST && enumSub_r == 32'h0) ?
                 {29'h0, FEAT_SUPPORTED} : 32'h0;

  always_comb
  begin
    case (paddr)
      CTRL4_OFF: rdVal = 32'(osEnable_r) << OS_EN_BIT;
      MODE_OFF:  rdVal = {26'h0, mode_r};
      OPLO_OFF:  rdVal = operand_r[31:0];
      OPHI_OFF:  rdVal = operand_r[63:32];
      STAT_OFF:  rdVal = {28'h0, fault_r, done_r, busy};
      RESLO_OFF: rdVal = result_r[31:0];
      RESHI_OFF: rdVal = result_r[63:32];
      BASE_OFF:  rdVal = areaBase_r;
      ENFN_OFF:  rdVal = enumFn_r;
      ENSUB_OFF: rdVal = enumSub_r;
      ENA_OFF:   rdVal = enumA;
      ENB_OFF:   rdVal = enumB;
      SIDX_OFF:  rdVal = {24'h0, stateIdx_r};
      SDATA_OFF: rdVal = stRdB;
      default:   rdVal = 32'h0;
    endcase
  end

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      prdata_r <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata_r <= rdVal;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      osEnable_r <= 1'b0;
      mode_r     <= '0;
      operand_r  <= 64'h0;
      areaBase_r <= 32'h0;
      enumFn_r   <= 32'h0;
      enumSub_r  <= 32'h0;
      stateIdx_r <= 8'h0;
    end
    else if (wrAcc)
    begin
      case (paddr)
        CTRL4_OFF: osEnable_r <= pwdata[OS_EN_BIT];
        MODE_OFF:  mode_r <= xss_cpu_mode_t'(pwdata[5:0]);
        OPLO_OFF:  operand_r[31:0] <= pwdata;
        OPHI_OFF:  operand_r[63:32] <= pwdata;
        BASE_OFF:
          if (!busy)
            areaBase_r <= {pwdata[31:2], 2'h0};
        ENFN_OFF:  enumFn_r <= pwdata;
        ENSUB_OFF: enumSub_r <= pwdata;
        SIDX_OFF:  stateIdx_r <= pwdata[7:0];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      featMask_r <= RESET_MASK;
      result_r   <= 64'h0;
    end
    else if (cmdWr && chkFault == FLT_NONE)
    begin
      if (cmd == CMD_SETBV)
        featMask_r <= operand_r;
      if (cmd == CMD_GETBV)
        result_r <= featMask_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      done_r  <= 1'b0;
      fault_r <= FLT_NONE;
    end
    else if (cmdWr)
    begin
      done_r  <= !engStart;
      fault_r <= chkFault;
    end
    else if (engEnd)
      done_r <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_r   <= ST_IDLE;
      isSave_r  <= 1'b0;
      is64_r    <= 1'b0;
      xfMem_r   <= 1'b0;
      ci_r      <= 3'h0;
      wi_r      <= 7'h0;
      xfCnt_r   <= 7'h0;
      selMask_r <= 64'h0;
      present_r <= 64'h0;
      memReq_r  <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (engStart)
          begin
            selMask_r <= operand_r & featMask_r;
            isSave_r  <= cmd != CMD_RESTORE;
            is64_r    <= mode_r.is64;
            wi_r      <= 7'h0;
            state_r   <= ST_HDR_RD;
          end
        ST_HDR_RD:
          if (!memReq_r.req)
          begin
            memReq_r.req   <= 1'b1;
            memReq_r.we    <= 1'b0;
            memReq_r.addr  <= areaBase_r + (wi_r[0] ? HDR_HI_OFF : HDR_OFF);
            memReq_r.wdata <= 32'h0;
          end
          else if (memAck)
          begin
            memReq_r.req <= 1'b0;
            if (wi_r[0])
            begin
              present_r[63:32] <= memRsp.rdata;
              ci_r    <= 3'h0;
              state_r <= ST_COMP;
            end
            else
            begin
              present_r[31:0] <= memRsp.rdata;
              wi_r <= 7'h1;
            end
          end
        ST_COMP:
          if (ci_r == 3'(NCOMP))
          begin
            wi_r <= 7'h0;
            if (sel12)
              state_r <= ST_MX;
            else
              state_r <= isSave_r ? ST_HDR_WR : ST_IDLE;
          end
          else if (selMask_r[COMP_BIT[ci_r]])
          begin
            xfMem_r <= isSave_r || present_r[COMP_BIT[ci_r]];
            if (!isSave_r && !present_r[COMP_BIT[ci_r]] && !is64_r &&
                (ci_r == 3'h1 || ci_r == 3'h2))
              xfCnt_r <= HALF_CNT;
            else
              xfCnt_r <= 7'(COMP_CNT[ci_r]);
            wi_r    <= 7'h0;
            state_r <= ST_XFER;
          end
          else
            ci_r <= ci_r + 3'h1;
        ST_XFER:
          if (xfMem_r && !memReq_r.req)
          begin
            memReq_r.req   <= 1'b1;
            memReq_r.we    <= isSave_r;
            memReq_r.addr  <= areaBase_r + areaOff(curIdx);
            memReq_r.wdata <= isSave_r ? stRdA : 32'h0;
          end
          else if (!xfMem_r || memAck)
          begin
            memReq_r.req <= 1'b0;
            if (wi_r == xfCnt_r - 7'h1)
            begin
              ci_r    <= ci_r + 3'h1;
              state_r <= ST_COMP;
            end
            else
              wi_r <= wi_r + 7'h1;
          end
        ST_MX:
          if (!memReq_r.req)
          begin
            memReq_r.req   <= 1'b1;
            memReq_r.we    <= isSave_r;
            memReq_r.addr  <= areaBase_r + areaOff(VCS_IDX);
            memReq_r.wdata <= isSave_r ? stRdA : 32'h0;
          end
          else if (memAck)
          begin
            memReq_r.req <= 1'b0;
            state_r      <= isSave_r ? ST_HDR_WR : ST_IDLE;
          end
        ST_HDR_WR:
          if (!memReq_r.req)
          begin
            memReq_r.req   <= 1'b1;
            memReq_r.we    <= 1'b1;
            memReq_r.addr  <= areaBase_r + (wi_r[0] ? HDR_HI_OFF : HDR_OFF);
            memReq_r.wdata <= wi_r[0] ? hdrNew[63:32] : hdrNew[31:0];
          end
          else if (memAck)
          begin
            memReq_r.req <= 1'b0;
            wi_r         <= 7'h1;
            if (wi_r[0])
              state_r <= ST_IDLE;
          end
      endcase
    end
  end

  a_mask_reset: assert property (
    @(posedge core_clk) !reset_n |=> featMask_r == RESET_MASK)
    else $error("mask not reset to legacy float only");

  a_mask_legal: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmdWr && cmd == CMD_SETBV && !maskLegal(operand_r)
    |=> fault_r != FLT_NONE && $stable(featMask_r))
    else $error("illegal mask write not faulted");

  a_setbv_priv: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmdWr && cmd == CMD_SETBV && osEnable_r && mode_r.cpl != 2'h0
    |=> fault_r == FLT_GP && featMask_r == $past(featMask_r))
    else $error("unprivileged mask write not faulted");

  a_ctrl_osen: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmdWr && cmd inside {CMD_GETBV, CMD_SETBV} && !osEnable_r
    |=> fault_r == FLT_UD && done_r)
    else $error("control access without os enable not refused");

  a_vec_enable: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmdWr && cmd == CMD_VEC && featMask_r[2:1] != 2'h3
    |=> fault_r == FLT_UD)
    else $error("vector op without state management ran");

  a_vec_mode: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmdWr && cmd == CMD_VEC &&
    (mode_r.sysMgmt || mode_r.opMode inside {MODE_REAL, MODE_V86})
    |=> fault_r == FLT_UD)
    else $error("vector op accepted in unsupported mode");

  a_save_any: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cmdWr && cmd inside {CMD_SAVE, CMD_RESTORE}
    |=> busy && fault_r == FLT_NONE && !done_r)
    else $error("save or restore refused");

  a_restore_sel: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    stWe && state_r == ST_XFER |-> selMask_r[COMP_BIT[ci_r]] && !isSave_r)
    else $error("restore wrote unselected component");

  a_hdr_bits: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    state_r == ST_HDR_WR && memReq_r.req && !wi_r[0]
    |-> memReq_r.addr == areaBase_r + HDR_OFF &&
        (memReq_r.wdata & selMask_r[31:0]) == selMask_r[31:0])
    else $error("saved component present bit not set");

  a_enum_size: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    enumFn_r == ENUM_FN_XST && enumSub_r == 32'h0
    |-> enumA == (featMask_r[2] ? 32'h0000_0340 : 32'h0000_0240) &&
        enumB[2:0] == 3'h7)
    else $error("enumeration result wrong");
endmodule // xss_engine

// >>> tb/xss_mem_model.sv
// Save area memory answering the engine's word requests
`timescale 1ns/1ps
module xss_mem_model
  import xss_pkg::*;
(
  input  wire xss_mreq_t core_clk_req,
  input  wire logic      core_clk,
  output xss_mrsp_t      memRsp
);
  logic [31:0] mem [1024];
  logic [2:0]  waitR = 3'h0;
  initial memRsp = '0;
  // Idle data toggles each cycle so a stale word can never pass
  always @(posedge core_clk)
  begin
    if (core_clk_req.req && memRsp.ack)
    begin
      memRsp.ack <= 1'b0;
      memRsp.rdata <= ~memRsp.rdata;
      if (core_clk_req.we)
        mem[core_clk_req.addr[11:2]] <= core_clk_req.wdata;
    end
    else if (core_clk_req.req && waitR == 3'h0)
    begin
      memRsp.ack <= 1'b1;
      memRsp.rdata <= mem[core_clk_req.addr[11:2]];
      waitR <= 3'($urandom_range(4));
    end
    else
    begin
      memRsp.rdata <= ~memRsp.rdata;
      if (core_clk_req.req)
        waitR <= waitR - 3'h1;
    end
  end
endmodule // xss_mem_model

// >>> tb/xss_engine_tb_top.sv
// Self-checking bench for the extended state save engine
`timescale 1ns/1ps
module xss_engine_tb_top
  import xss_pkg::*;
();
  logic        coreClk = 1'b0;
  logic        resetN = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  xss_mreq_t   memReq;
  xss_mrsp_t   memRsp;
  int          mismatches = 0;
  int          numChecks = 0;
  logic [31:0] d;
  logic [31:0] w0;
  logic        e;
  logic [63:0] bad [3] = '{64'h6, 64'h5, 64'hf};

  always #20 coreClk = ~coreClk;

  xss_engine xss_engine_inst (.core_clk(coreClk), .reset_n(resetN),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memReq(memReq), .memRsp(memRsp));
  xss_mem_model xss_mem_model_inst (.core_clk_req(memReq),
    .core_clk(coreClk), .memRsp(memRsp));

  function automatic logic [31:0] areaSize(input logic [63:0] m);
    return AREA_SIZE_BASE + (m[2] ? UPPER_AREA_SIZE : 32'h0);
  endfunction

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    numChecks++;
    if (g !== x)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  // Idle cycle after each transfer keeps strobes from being set twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge coreClk);
    penable <= 1'b1;
    @(posedge coreClk);
    while (pready !== 1'b1)
      @(posedge coreClk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge coreClk);
  endtask

  task automatic setOp(input logic [63:0] v);
    apb(1'b1, OPLO_OFF, v[31:0]);
    apb(1'b1, OPHI_OFF, v[63:32]);
  endtask

  task automatic cmd(input xss_cmd_t c, input xss_fault_t f);
    apb(1'b1, CMD_OFF, {29'h0, c});
    apb(1'b0, STAT_OFF, 32'h0);
    while (d[0] === 1'b1)
      apb(1'b0, STAT_OFF, 32'h0);
    chk("fault", {30'h0, f}, {30'h0, d[3:2]});
    chk("done", 32'h1, {31'h0, d[1]});
  endtask

  task automatic st(input logic [7:0] i, input logic [31:0] x);
    apb(1'b1, SIDX_OFF, {24'h0, i});
    apb(1'b0, SDATA_OFF, 32'h0);
    chk("state", x, d);
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge coreClk);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(15111));
    for (int i = 0; i < 256; i++)
      xss_mem_model_inst.mem[i] = $urandom;
    repeat (16) @(posedge coreClk);
    resetN <= 1'b1;
    @(posedge coreClk);
    apb(1'b1, MODE_OFF, 32'h0b);
    cmd(CMD_VEC, FLT_UD);
    cmd(CMD_GETBV, FLT_UD);
    apb(1'b1, CTRL4_OFF, 32'h0004_0000);
    cmd(CMD_VEC, FLT_UD);
    cmd(CMD_GETBV, FLT_NONE);
    apb(1'b0, RESLO_OFF, 32'h0);
    chk("mask", 32'h1, d);
    apb(1'b1, ENFN_OFF, ENUM_FN_XST);
    apb(1'b1, ENSUB_OFF, 32'h0);
    apb(1'b0, ENA_OFF, 32'h0);
    chk("size", areaSize(64'h1), d);
    apb(1'b0, ENB_OFF, 32'h0);
    chk("support", 32'h7, d);
    for (int i = 0; i < 3; i++)
    begin
      setOp(bad[i]);
      cmd(CMD_SETBV, FLT_GP);
    end
    // Random upper bits; bit 3 alone already makes the mask illegal
    setOp({$urandom, $urandom} | 64'h8);
    cmd(CMD_SETBV, FLT_GP);
    apb(1'b1, MODE_OFF, 32'h3b);
    // legal mask with bit 0 set refused at ring 3, then written at ring 0
    setOp(64'h7);
    cmd(CMD_SETBV, FLT_GP);
    apb(1'b1, MODE_OFF, 32'h0b);
    cmd(CMD_SETBV, FLT_NONE);
    apb(1'b0, ENA_OFF, 32'h0);
    chk("size", areaSize(64'h7), d);
    cmd(CMD_VEC, FLT_NONE);
    apb(1'b1, MODE_OFF, 32'h02);
    cmd(CMD_VEC, FLT_NONE);
    apb(1'b1, MODE_OFF, 32'h01);
    cmd(CMD_VEC, FLT_UD);
    apb(1'b1, MODE_OFF, 32'h00);
    cmd(CMD_VEC, FLT_UD);
    apb(1'b1, MODE_OFF, 32'h07);
    cmd(CMD_VEC, FLT_UD);
    xss_mem_model_inst.mem[128] = 32'h0;
    xss_mem_model_inst.mem[129] = 32'h0;
    apb(1'b1, MODE_OFF, 32'h00);
    cmd(CMD_RESTORE, FLT_NONE);
    st(FCTL_IDX, FCTL_INIT);
    st(FSTAT_IDX, FSTAT_INIT);
    st(FTAG_IDX, FTAG_INIT);
    st(8'h40, 32'h0);
    st(EXT_IDX, 32'h0);
    st(VCS_IDX, xss_mem_model_inst.mem[32]);
    xss_mem_model_inst.mem[128] = 32'h1;
    w0 = xss_mem_model_inst.mem[0];
    apb(1'b1, MODE_OFF, 32'h0b);
    setOp(64'h1);
    cmd(CMD_RESTORE, FLT_NONE);
    st(FCTL_IDX, w0);
    st(8'h40, 32'h0);
    xss_mem_model_inst.mem[128] = 32'h0;
    setOp(64'h2);
    cmd(CMD_SAVE, FLT_NONE);
    chk("present", 32'h2, xss_mem_model_inst.mem[128]);
    chk("float image", w0, xss_mem_model_inst.mem[0]);
    chk("narrow", 32'h0, xss_mem_model_inst.mem[64]);
    // optimized save only after a full save
    setOp(64'h7);
    cmd(CMD_SAVEOPT, FLT_NONE);
    chk("present", 32'h7, xss_mem_model_inst.mem[128]);
    chk("upper", 32'h0, xss_mem_model_inst.mem[144]);
    // Present bits clear in 64-bit mode: all sixteen registers go to zero
    xss_mem_model_inst.mem[128] = 32'h0;
    setOp(64'h6);
    cmd(CMD_RESTORE, FLT_NONE);
    st(8'h7f, 32'h0);
    st(8'hbf, 32'h0);
    st(FCTL_IDX, w0);
    st(VCS_IDX, xss_mem_model_inst.mem[32]);
    // Mid-run reset must bring the wide mask back to its reset value
    resetN <= 1'b0;
    repeat (2) @(posedge coreClk);
    resetN <= 1'b1;
    @(posedge coreClk);
    apb(1'b1, CTRL4_OFF, 32'h0004_0000);
    cmd(CMD_GETBV, FLT_NONE);
    apb(1'b0, RESLO_OFF, 32'h0);
    chk("mask", 32'h1, d);
    apb(1'b0, 12'h03c, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, d);
    chk("pready", 32'h1, {31'h0, pready});
    print_verdict();
  end
endmodule // xss_engine_tb_top
